// ---- src/host_cmd_pkg.sv ----
// package: command codes, register layouts and reset values for the decoder
package host_cmd_pkg;

  localparam int NUM_CHANNELS = 4;

  // command codes
  localparam logic [7:0] CMD_DEACTIVATE = 8'h00;
  localparam logic [7:0] CMD_SOFT_RESET = 8'h02;
  localparam logic [7:0] CMD_HARD_RESET = 8'h04;
  localparam logic [7:0] CMD_NO_OP      = 8'h06;
  localparam logic [7:0] CMD_ACTIVATE   = 8'h0e;
  localparam logic [6:0] CMD_TX_SLOT    = 7'h20; // 40/41h without r/w bit
  localparam logic [6:0] CMD_RX_SLOT    = 7'h21; // 42/43h without r/w bit

  // field positions and bit counts
  localparam int DIR_BIT      = 0;
  localparam int HIGHWAY_BIT  = 7;
  localparam int SLOT_MSB     = 6;
  localparam int BYTE_BITS    = 8;
  localparam int RESET_EDGES  = 16;

  // count of frame strobes before valid samples after activation
  localparam logic [1:0] FRAMES_TO_VALID = 2'h2;

  // reset values
  localparam logic [3:0] ENABLE_RESET  = 4'hf;
  localparam logic       ACTIVE_RESET  = 1'b0;

  typedef struct packed {
    logic       highway; // 0 = highway a, 1 = highway b
    logic [6:0] slot;    // time slot 0..127
  } slot_reg_t;

  typedef enum logic [1:0] {
    ST_COMMAND   = 2'b00,
    ST_WRITE     = 2'b01,
    ST_READ      = 2'b10
  } port_state_t;

  // default slot for channel n: slot n on highway a
  function automatic slot_reg_t slot_default(input int n);
    slot_default = '{highway: 1'b0, slot: 7'(n)};
  endfunction

endpackage

// ---- src/host_command_decoder.sv ----
// host_command_decoder: serial command decoder of the four-channel codec
`timescale 1ns/1ps

module host_command_decoder
  import host_cmd_pkg::*;
#(
  parameter bit HAS_HIGHWAY_B = 1'b1 // 0 for the smaller package
) (
  input  wire logic       SYS_CLK_IN,          // 250 mhz system clock
  input  wire logic       RESET_IN,            // sync reset, active high
  input  wire logic       RESET_PIN_N_IN,      // device reset pin, async
  input  wire logic       HOST_BIT_CLOCK_IN,   // serial port bit clock
  input  wire logic       HOST_SELECT_N_IN,    // serial port select, low
  input  wire logic       HOST_DATA_LINE_IN,   // data line input level
  input  wire logic       FRAME_STROBE_IN,     // pcm frame strobe
  input  wire logic [3:0] CHANNEL_ENABLE_IN,   // channel enable bits
  input  wire logic       HIGHWAY_SIGNALING_ENABLE_IN, // signaling mode
  output logic            HOST_DATA_LINE_OUT,  // data line drive value
  output logic            HOST_DATA_LINE_OE_OUT, // data line enable
  output logic [3:0]      CHANNEL_ACTIVE_FLAG_OUT, // per channel active
  output logic [3:0]      PCM_OUTPUT_ENABLE_OUT,   // highway drive enable
  output logic [3:0]      PCM_INPUT_ENABLE_OUT,    // highway sample enable
  output logic [3:0]      PCM_SAMPLES_VALID_OUT,   // samples may be sent
  output logic [3:0]      ANALOG_OUTPUT_ENABLE_OUT, // analog driver on
  output slot_reg_t [3:0] TX_SLOT_OUT,         // transmit slot per channel
  output slot_reg_t [3:0] RX_SLOT_OUT,         // receive slot per channel
  output logic            SOFT_RESET_PULSE_OUT, // per channel defaults
  output logic [3:0]      SOFT_RESET_MASK_OUT   // channels soft reset hits
);

  // synchronisers: first stage read only by second
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic       clk_prev_reg;
  logic       sel_prev_reg;
  logic       fs_prev_reg;
  logic       rst_pin1_reg;
  logic       rst_pin2_reg;

  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      // bit clock and select idle high; matching avoids a false edge
      sync1_reg    <= 4'h3;
      sync2_reg    <= 4'h3;
      clk_prev_reg <= 1'b1;
      sel_prev_reg <= 1'b1;
      fs_prev_reg  <= 1'b0;
      rst_pin1_reg <= 1'b1;
      rst_pin2_reg <= 1'b1;
    end else begin
      sync1_reg    <= {FRAME_STROBE_IN, HOST_DATA_LINE_IN,
                       HOST_BIT_CLOCK_IN, HOST_SELECT_N_IN};
      sync2_reg    <= sync1_reg;
      clk_prev_reg <= sync2_reg[1];
      sel_prev_reg <= sync2_reg[0];
      fs_prev_reg  <= sync2_reg[3];
      rst_pin1_reg <= RESET_PIN_N_IN;
      rst_pin2_reg <= rst_pin1_reg;
    end
  end

  logic sel_n;
  logic clk_rise;
  logic clk_fall;
  logic sel_fall;
  logic sel_rise;
  logic fs_rise;
  assign sel_n    = sync2_reg[0];
  assign clk_rise = sync2_reg[1] & ~clk_prev_reg;
  assign clk_fall = ~sync2_reg[1] & clk_prev_reg;
  assign sel_fall = ~sel_n & sel_prev_reg;
  assign sel_rise = sel_n & ~sel_prev_reg;
  assign fs_rise  = sync2_reg[3] & ~fs_prev_reg;

  // byte shifter and edge counter for one select low period
  logic [7:0] shift_reg;
  logic [4:0] edges_reg;

  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN || sel_fall) begin
      shift_reg <= 8'h00;
      edges_reg <= 5'h00;
    end else if (!sel_n && clk_rise) begin
      shift_reg <= {shift_reg[6:0], sync2_reg[2]};
      if (edges_reg != 5'(RESET_EDGES))
        edges_reg <= edges_reg + 5'h01;
    end
  end

  // byte complete at select rise; keeps last eight bits
  logic byte_done;
  logic long_reset;
  assign byte_done  = sel_rise && edges_reg >= 5'(BYTE_BITS) &&
                      edges_reg < 5'(RESET_EDGES);
  assign long_reset = sel_rise && edges_reg == 5'(RESET_EDGES);

  port_state_t state_reg;
  logic        target_rx_reg;
  logic [7:0]  out_byte_reg;
  logic [2:0]  out_idx_reg;
  logic        hard_reset;
  logic        cmd_byte;
  logic        is_slot_cmd;
  logic        enable_any;
  int          first_ch;

  assign cmd_byte   = byte_done && state_reg == ST_COMMAND;
  assign hard_reset = RESET_IN || !rst_pin2_reg || long_reset ||
                      (cmd_byte && shift_reg == CMD_HARD_RESET);
  assign is_slot_cmd = shift_reg[7:1] == CMD_TX_SLOT ||
                       shift_reg[7:1] == CMD_RX_SLOT;
  assign enable_any = |CHANNEL_ENABLE_IN;

  // first enabled channel supplies read data
  always_comb begin
    first_ch = 0;
    for (int i = NUM_CHANNELS - 1; i >= 0; i--)
      if (CHANNEL_ENABLE_IN[i])
        first_ch = i;
  end

  slot_reg_t [3:0] tx_slot_reg;
  slot_reg_t [3:0] rx_slot_reg;

  // command port sequencing
  always_ff @(posedge SYS_CLK_IN) begin
    if (hard_reset) begin
      state_reg     <= ST_COMMAND;
      target_rx_reg <= 1'b0;
      out_byte_reg  <= 8'h00;
    end else if (byte_done) begin
      case (state_reg)
        ST_COMMAND: begin
          if (is_slot_cmd) begin
            target_rx_reg <= shift_reg[1];
            if (shift_reg[DIR_BIT]) begin
              state_reg    <= ST_READ;
              out_byte_reg <= shift_reg[1] ? rx_slot_reg[first_ch]
                                           : tx_slot_reg[first_ch];
            end else begin
              state_reg <= ST_WRITE;
            end
          end
        end
        ST_WRITE: begin
          state_reg <= ST_COMMAND;
        end
        ST_READ: begin
          state_reg <= ST_COMMAND; // read byte consumed first
        end
        default: begin
          state_reg <= ST_COMMAND;
        end
      endcase
    end
  end

  // read data drive: msb first, next bit after each falling edge that follows a rising edge
  always_ff @(posedge SYS_CLK_IN) begin
    if (hard_reset || sel_fall)
      out_idx_reg <= 3'h7;
    else if (!sel_n && clk_fall && state_reg == ST_READ &&
             edges_reg != 5'h00)
      out_idx_reg <= out_idx_reg - 3'h1;
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (hard_reset) begin
      HOST_DATA_LINE_OUT    <= 1'b0;
      HOST_DATA_LINE_OE_OUT <= 1'b0;
    end else begin
      // data appears as soon as select falls in a read, clock or not
      HOST_DATA_LINE_OUT    <= out_byte_reg[out_idx_reg];
      HOST_DATA_LINE_OE_OUT <= !sel_n && state_reg == ST_READ;
    end
  end

  // write byte lands in enabled channels; unmasked bits stored as given
  logic write_byte;
  assign write_byte = byte_done && state_reg == ST_WRITE;

  logic [3:0] act_reg;
  logic [1:0] fs_count_reg [NUM_CHANNELS];

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHANNELS; ch++) begin : g_chan
      logic soft_hit;
      assign soft_hit = cmd_byte && shift_reg == CMD_SOFT_RESET &&
                        CHANNEL_ENABLE_IN[ch];

      // slot registers survive soft reset
      always_ff @(posedge SYS_CLK_IN) begin
        if (hard_reset) begin
          tx_slot_reg[ch] <= slot_default(ch);
          rx_slot_reg[ch] <= slot_default(ch);
        end else if (write_byte && CHANNEL_ENABLE_IN[ch]) begin
          if (target_rx_reg)
            rx_slot_reg[ch] <= '{highway: shift_reg[HIGHWAY_BIT] &
                                          HAS_HIGHWAY_B,
                                 slot: shift_reg[SLOT_MSB:0]};
          else
            tx_slot_reg[ch] <= '{highway: shift_reg[HIGHWAY_BIT] &
                                          HAS_HIGHWAY_B,
                                 slot: shift_reg[SLOT_MSB:0]};
        end
      end

      // active flag; soft reset returns channel to standby default
      always_ff @(posedge SYS_CLK_IN) begin
        if (hard_reset || soft_hit) begin
          act_reg[ch] <= ACTIVE_RESET;
        end else if (cmd_byte && CHANNEL_ENABLE_IN[ch]) begin
          if (shift_reg == CMD_DEACTIVATE)
            act_reg[ch] <= 1'b0;
          else if (shift_reg == CMD_ACTIVATE)
            act_reg[ch] <= 1'b1;
        end
      end

      // frame strobe count gating valid samples after activation
      always_ff @(posedge SYS_CLK_IN) begin
        if (hard_reset || soft_hit || !act_reg[ch])
          fs_count_reg[ch] <= 2'h0;
        else if (cmd_byte && shift_reg == CMD_ACTIVATE &&
                 CHANNEL_ENABLE_IN[ch])
          fs_count_reg[ch] <= 2'h0; // re-activation restarts wait
        else if (fs_rise && fs_count_reg[ch] != FRAMES_TO_VALID)
          fs_count_reg[ch] <= fs_count_reg[ch] + 2'h1;
      end

      // standby outputs
      always_ff @(posedge SYS_CLK_IN) begin
        if (hard_reset) begin
          PCM_OUTPUT_ENABLE_OUT[ch]    <= 1'b0;
          PCM_INPUT_ENABLE_OUT[ch]     <= 1'b0;
          PCM_SAMPLES_VALID_OUT[ch]    <= 1'b0;
          ANALOG_OUTPUT_ENABLE_OUT[ch] <= 1'b0;
        end else begin
          PCM_OUTPUT_ENABLE_OUT[ch]    <= act_reg[ch] |
                                          HIGHWAY_SIGNALING_ENABLE_IN;
          PCM_INPUT_ENABLE_OUT[ch]     <= act_reg[ch];
          PCM_SAMPLES_VALID_OUT[ch]    <= act_reg[ch] &&
                               fs_count_reg[ch] == FRAMES_TO_VALID;
          ANALOG_OUTPUT_ENABLE_OUT[ch] <= act_reg[ch];
        end
      end
    end
  endgenerate

  // soft reset strobe for channel state outside this block
  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      SOFT_RESET_PULSE_OUT <= 1'b0;
      SOFT_RESET_MASK_OUT  <= 4'h0;
    end else begin
      SOFT_RESET_PULSE_OUT <= cmd_byte && shift_reg == CMD_SOFT_RESET;
      SOFT_RESET_MASK_OUT  <= CHANNEL_ENABLE_IN;
    end
  end

  // no-operation and unlisted codes fall through untouched
  assign CHANNEL_ACTIVE_FLAG_OUT = act_reg;
  assign TX_SLOT_OUT             = tx_slot_reg;
  assign RX_SLOT_OUT             = rx_slot_reg;

endmodule // host_command_decoder

// ---- verification/host_command_decoder_chk.sv ----
// checker: port assertions for the host command decoder
`timescale 1ns/1ps
module host_command_decoder_chk
  import host_cmd_pkg::*;
(
  input wire logic            SYS_CLK_IN,                  // clock
  input wire logic            RESET_IN,                    // reset
  input wire logic            HOST_SELECT_N_IN,            // select
  input wire logic            HIGHWAY_SIGNALING_ENABLE_IN, // signaling
  input wire logic            HOST_DATA_LINE_OE_OUT,       // line drive
  input wire logic [3:0]      CHANNEL_ACTIVE_FLAG_OUT,     // active
  input wire logic [3:0]      PCM_OUTPUT_ENABLE_OUT,       // pcm out
  input wire logic [3:0]      PCM_INPUT_ENABLE_OUT,        // pcm in
  input wire logic [3:0]      PCM_SAMPLES_VALID_OUT,       // valid
  input wire logic [3:0]      ANALOG_OUTPUT_ENABLE_OUT,    // analog
  input wire slot_reg_t [3:0] TX_SLOT_OUT,                 // tx slots
  input wire slot_reg_t [3:0] RX_SLOT_OUT,                 // rx slots
  input wire logic            SOFT_RESET_PULSE_OUT,        // pulse
  input wire logic [3:0]      SOFT_RESET_MASK_OUT          // mask
);
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (RESET_IN);
  logic [3:0] prev_act_reg;
  logic [3:0] idle;
  // enables are registered, so standby counts only after two idle cycles
  always_ff @(posedge SYS_CLK_IN) prev_act_reg <= CHANNEL_ACTIVE_FLAG_OUT;
  assign idle = ~CHANNEL_ACTIVE_FLAG_OUT & ~prev_act_reg;
  chk_reset_slots: assert property ($past(RESET_IN) |->
    TX_SLOT_OUT == 32'h03020100 && RX_SLOT_OUT == 32'h03020100 &&
    CHANNEL_ACTIVE_FLAG_OUT == 4'h0) else $error("reset values wrong");
  chk_idle_input: assert property (
    (PCM_INPUT_ENABLE_OUT & idle) == 4'h0)
    else $error("pcm input on in standby");
  chk_idle_analog: assert property (
    (ANALOG_OUTPUT_ENABLE_OUT & idle) == 0)
    else $error("analog output on in standby");
  chk_idle_output: assert property (!HIGHWAY_SIGNALING_ENABLE_IN &&
    !$past(HIGHWAY_SIGNALING_ENABLE_IN) |->
    (PCM_OUTPUT_ENABLE_OUT & idle) == 0)
    else $error("pcm output driven in standby");
  chk_signal_drive: assert property (!$past(RESET_IN) &&
    HIGHWAY_SIGNALING_ENABLE_IN && $past(HIGHWAY_SIGNALING_ENABLE_IN) |->
    PCM_OUTPUT_ENABLE_OUT == 4'hf) else $error("signaling not driven");
  chk_valid_active: assert property (
    (PCM_SAMPLES_VALID_OUT & idle) == 0)
    else $error("samples valid while standby");
  chk_activate_wait: assert property (
    $rose(CHANNEL_ACTIVE_FLAG_OUT[0]) |-> !PCM_SAMPLES_VALID_OUT[0] [*2])
    else $error("valid too early");
  chk_soft_pulse: assert property (SOFT_RESET_PULSE_OUT |=>
    !SOFT_RESET_PULSE_OUT) else $error("soft reset pulse too long");
  chk_soft_clears: assert property (SOFT_RESET_PULSE_OUT |-> ##[0:2]
    (CHANNEL_ACTIVE_FLAG_OUT & SOFT_RESET_MASK_OUT) == 4'h0)
    else $error("soft reset left channel active");
  chk_select_idle: assert property (HOST_SELECT_N_IN [*6] |->
    !HOST_DATA_LINE_OE_OUT) else $error("line driven while deselected");
endmodule // host_command_decoder_chk

bind host_command_decoder host_command_decoder_chk u_chk (
  .SYS_CLK_IN(SYS_CLK_IN), .RESET_IN(RESET_IN),
  .HOST_SELECT_N_IN(HOST_SELECT_N_IN),
  .HIGHWAY_SIGNALING_ENABLE_IN(HIGHWAY_SIGNALING_ENABLE_IN),
  .HOST_DATA_LINE_OE_OUT(HOST_DATA_LINE_OE_OUT),
  .CHANNEL_ACTIVE_FLAG_OUT(CHANNEL_ACTIVE_FLAG_OUT),
  .PCM_OUTPUT_ENABLE_OUT(PCM_OUTPUT_ENABLE_OUT),
  .PCM_INPUT_ENABLE_OUT(PCM_INPUT_ENABLE_OUT),
  .PCM_SAMPLES_VALID_OUT(PCM_SAMPLES_VALID_OUT),
  .ANALOG_OUTPUT_ENABLE_OUT(ANALOG_OUTPUT_ENABLE_OUT),
  .TX_SLOT_OUT(TX_SLOT_OUT), .RX_SLOT_OUT(RX_SLOT_OUT),
  .SOFT_RESET_PULSE_OUT(SOFT_RESET_PULSE_OUT),
  .SOFT_RESET_MASK_OUT(SOFT_RESET_MASK_OUT));

// ---- verification/host_command_decoder_test.sv ----
// testbench: host model drives the decoder, a bench model predicts it
`timescale 1ns/1ps
module host_command_decoder_test;
  import host_cmd_pkg::*;
  logic            clk, rst, pin_n, fs, sig, bclk, sel_n, din, dout, doe;
  logic [3:0]      en, act_o, pcm_o, pcm_i, valid_o, ana_o;
  slot_reg_t [3:0] tx_o, rx_o, tx_s, rx_s;
  logic [7:0]      b, got, exp;
  int              tx[4], rx[4], act, err_total, checks, cycles;
  int              seed = 32'he8cd;

  host_command_decoder u_dut (.SYS_CLK_IN(clk), .RESET_IN(rst),
    .RESET_PIN_N_IN(pin_n), .HOST_BIT_CLOCK_IN(bclk),
    .HOST_SELECT_N_IN(sel_n), .HOST_DATA_LINE_IN(din),
    .FRAME_STROBE_IN(fs), .CHANNEL_ENABLE_IN(en),
    .HIGHWAY_SIGNALING_ENABLE_IN(sig), .HOST_DATA_LINE_OUT(dout),
    .HOST_DATA_LINE_OE_OUT(doe), .CHANNEL_ACTIVE_FLAG_OUT(act_o),
    .PCM_OUTPUT_ENABLE_OUT(pcm_o), .PCM_INPUT_ENABLE_OUT(pcm_i),
    .PCM_SAMPLES_VALID_OUT(valid_o), .ANALOG_OUTPUT_ENABLE_OUT(ana_o),
    .TX_SLOT_OUT(tx_o), .RX_SLOT_OUT(rx_o), .SOFT_RESET_PULSE_OUT(),
    .SOFT_RESET_MASK_OUT());
  host_serial_model host (.data_in(dout), .data_oe_in(doe),
    .bit_clock_out(bclk), .select_n_out(sel_n), .data_out(din));
  // small package build: same stimulus, highway b must read as a
  host_command_decoder #(.HAS_HIGHWAY_B(1'b0)) u_dut_small (
    .SYS_CLK_IN(clk), .RESET_IN(rst), .RESET_PIN_N_IN(pin_n),
    .HOST_BIT_CLOCK_IN(bclk), .HOST_SELECT_N_IN(sel_n),
    .HOST_DATA_LINE_IN(din), .FRAME_STROBE_IN(fs),
    .CHANNEL_ENABLE_IN(en), .HIGHWAY_SIGNALING_ENABLE_IN(sig),
    .HOST_DATA_LINE_OUT(), .HOST_DATA_LINE_OE_OUT(),
    .CHANNEL_ACTIVE_FLAG_OUT(), .PCM_OUTPUT_ENABLE_OUT(),
    .PCM_INPUT_ENABLE_OUT(), .PCM_SAMPLES_VALID_OUT(),
    .ANALOG_OUTPUT_ENABLE_OUT(), .TX_SLOT_OUT(tx_s),
    .RX_SLOT_OUT(rx_s), .SOFT_RESET_PULSE_OUT(),
    .SOFT_RESET_MASK_OUT());

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // hang guard: the run needs well under this many cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      err_total++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic defaults();
    act = 0;
    for (int i = 0; i < 4; i++) begin
      tx[i] = i;
      rx[i] = i;
    end
  endtask
  task automatic cmp_all();
    logic [31:0] t, r;
    for (int i = 0; i < 4; i++) begin
      t[8*i +: 8] = tx[i][7:0];
      r[8*i +: 8] = rx[i][7:0];
    end
    check("tx slots", tx_o, t);
    check("rx slots", rx_o, r);
    check("active flags", act_o, act[3:0]);
    check("small tx slots", tx_s, t & 32'h7f7f7f7f);
    check("small rx slots", rx_s, r & 32'h7f7f7f7f);
  endtask
  // whole byte frame; carries command codes and slot data bytes alike
  task automatic cmd(input logic [7:0] c);
    host.frame({8'h00, c}, 8, got);
  endtask

  initial begin
    rst = 1'b1; pin_n = 1'b1; fs = 1'b0; sig = 1'b0; en = 4'hf;
    defaults();
    repeat (20) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    cmp_all();
    for (int k = 0; k < 8; k++) begin
      en = 4'($random(seed));
      if (en == 4'h0) en = 4'h8;
      b = 8'($random(seed));
      cmd(k[0] ? 8'h42 : 8'h40);
      cmd(b);
      for (int i = 0; i < 4; i++)
        if (en[i] && k[0]) rx[i] = b; else if (en[i]) tx[i] = b;
      cmp_all();
      cmd(k[0] ? 8'h43 : 8'h41);
      cmd(8'h00); // a missed read state would decode this as deactivate
      for (int i = 3; i >= 0; i--)
        if (en[i]) exp = k[0] ? rx[i][7:0] : tx[i][7:0];
      check("read byte", got, exp);
    end
    $display("done slot writes and reads");
    en = 4'h5;
    cmd(CMD_ACTIVATE);
    act = 5;
    cmp_all();
    for (int f = 0; f < 2; f++) begin
      check("valid early", valid_o, 4'h0);
      fs = 1'b1; repeat (8) @(negedge clk);
      fs = 1'b0; repeat (8) @(negedge clk);
    end
    check("valid", valid_o, 4'h5);
    check("pcm out", pcm_o, 4'h5);
    check("analog", ana_o, 4'h5);
    en = 4'h1;
    cmd(CMD_DEACTIVATE);
    act = 4;
    cmp_all();
    check("pcm in", pcm_i, 4'h4);
    sig = 1'b1; repeat (4) @(negedge clk);
    check("signaling drive", pcm_o, 4'hf);
    sig = 1'b0; en = 4'hf;
    cmd(CMD_NO_OP);
    host.frame(16'h000e, 7, got);
    cmp_all();
    host.frame(16'h010e, 9, got);
    act = 15;
    cmp_all();
    en = 4'h6;
    cmd(CMD_SOFT_RESET);
    act = 9;
    cmp_all();
    $display("done state commands");
    en = 4'h0;
    cmd(CMD_HARD_RESET);
    defaults();
    cmp_all();
    en = 4'hf;
    cmd(8'h40);
    cmd(8'h7f);
    host.frame(16'hffff, 16, got);
    cmp_all();
    cmd(8'h42);
    cmd(8'h85);
    pin_n = 1'b0; repeat (8) @(negedge clk);
    pin_n = 1'b1; repeat (8) @(negedge clk);
    cmp_all();
    $display("done resets");
    close_out();
  end
endmodule // host_command_decoder_test

// ---- verification/host_serial_model.sv ----
// host model: shifts n bits (up to two bytes) over the serial port per select low
`timescale 1ns/1ps
module host_serial_model (
  input  wire logic data_in,       // device line drive value
  input  wire logic data_oe_in,    // device drives the line
  output logic      bit_clock_out, // serial bit clock, idles high
  output logic      select_n_out,  // select, low active
  output logic      data_out       // resolved line level
);
  logic drv;
  initial begin
    bit_clock_out = 1'b1;
    select_n_out = 1'b1;
    drv = 1'b0;
  end
  // line level: the device wins while it drives
  assign data_out = data_oe_in ? data_in : drv;
  // n rising edges, msb first; bit clock stands still between frames
  task automatic frame(input logic [15:0] bits, input int n,
                       output logic [7:0] got);
    got = 8'h00;
    select_n_out = 1'b0;
    #40;
    for (int i = n - 1; i >= 0; i--) begin
      bit_clock_out = 1'b0;
      drv = bits[i];
      #32;
      bit_clock_out = 1'b1;
      got = {got[6:0], data_out};
      #32;
    end
    select_n_out = 1'b1;
    drv = ~drv; // released line must not keep its last value
    #80;
  endtask
endmodule // host_serial_model
